// ---- poe_seq_map.svh ----
// constants for the port restart sequencer and its host controller
// assumes a single 200 MHz clock shared by both ends
`ifndef POE_SEQ_MAP_SVH
`define POE_SEQ_MAP_SVH

`define NPORT            8
`define CLK_MHZ          200
`define LONG_CLASS_MS    100
`define MPS_HOLD_MS      6
`define MPS_WIN_MS       320
`define COOL_MS          1000
`define FOLDBACK_DEF     8'h40

// synchroniser lanes of the device analog status inputs
`define S_DET            0
`define S_CLS            1
`define S_STF            2
`define S_PCF            3
`define S_ILF            4
`define S_MPS            5

// host register byte offsets
`define OFS_CTRL         8'h00
`define OFS_CMD          8'h04
`define OFS_POLICE       8'h08
`define OFS_PSTAT        8'h0C
`define OFS_ISTAT        8'h10
`define OFS_IMASK        8'h14

// field positions
`define CTRL_CFG_BIT     0
`define CTRL_STRAP_LSB   4
`define CMD_DET_LSB      0
`define CMD_CLS_LSB      8
`define CMD_OFF_LSB      16
`define IST_DISC_LSB     8

`endif

// ---- poe_seq_pkg.sv ----
// types shared by the sequencer and the host controller
// assumes poe_seq_map.svh for the port count
`include "poe_seq_map.svh"

package poe_seq_pkg;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_DETECT = 6'h02,
    ST_CLASS  = 6'h04,
    ST_LONG   = 6'h08,
    ST_POWER  = 6'h10,
    ST_COOL   = 6'h20
  } port_state_t;

  typedef struct packed {
    port_state_t [`NPORT-1:0]        st;
    logic        [`NPORT-1:0][31:0]  tmr;
    logic        [`NPORT-1:0][31:0]  acc;
    logic        [`NPORT-1:0]        det_en;
    logic        [`NPORT-1:0]        cls_en;
    logic        [5:0][`NPORT-1:0]   s1;
    logic        [5:0][`NPORT-1:0]   s2;
    logic        [3:0]               a1;
    logic        [3:0]               a2;
    logic        [`NPORT-1:0]        fault_ev;
    logic        [`NPORT-1:0]        disc_ev;
    logic        [`NPORT-1:0]        pwr_en;
    logic        [`NPORT-1:0]        det_act;
    logic        [`NPORT-1:0]        cls_act;
    logic        [`NPORT-1:0][7:0]   lim;
    logic        [`NPORT-1:0][7:0]   pcut;
  } dev_state_t;

  typedef struct packed {
    logic [1:0]        sv1;
    logic [1:0]        sv2;
    logic              rst_n;
    logic              cfg;
    logic [3:0]        strap;
    logic [7:0]        police;
    logic [`NPORT-1:0] det_set;
    logic [`NPORT-1:0] cls_set;
    logic [`NPORT-1:0] pwr_off;
    logic [15:0]       ists;
    logic [15:0]       imask;
    logic              act;
    logic              wr;
    logic [7:0]        addr;
    logic [31:0]       rdata;
    logic              irq;
  } host_state_t;

endpackage

// ---- poe_link_if.sv ----
// link between the port sequencer and the host controller
// assumes both ends run on the same clock
`timescale 1ns/1ps
`include "poe_seq_map.svh"

interface poe_link_if;
  logic              dev_rst_n;
  logic              cfg_loaded;
  logic [3:0]        strap;
  logic [7:0]        police;
  logic [`NPORT-1:0] det_set;
  logic [`NPORT-1:0] cls_set;
  logic [`NPORT-1:0] pwr_off;
  logic [`NPORT-1:0] det_en;
  logic [`NPORT-1:0] cls_en;
  logic [`NPORT-1:0] powered;
  logic [`NPORT-1:0] fault_ev;
  logic [`NPORT-1:0] disc_ev;
  logic [3:0]        dev_addr;

  modport dev (
    input  dev_rst_n, cfg_loaded, strap, police, det_set, cls_set, pwr_off,
    output det_en, cls_en, powered, fault_ev, disc_ev, dev_addr
  );

  modport host (
    output dev_rst_n, cfg_loaded, strap, police, det_set, cls_set, pwr_off,
    input  det_en, cls_en, powered, fault_ev, disc_ev, dev_addr
  );
endinterface

// ---- poe_port_restart_sequencer.sv ----
// eight-port detect, classify, power and restart sequencer
// assumes host commands arrive as one-cycle pulses on the link clock
// and analog status inputs arrive asynchronously from the port front end
`timescale 1ns/1ps
`include "poe_seq_map.svh"

// Operation
// R1 - power down on off, disconnect, fault
// R2 - disconnect restarts cycles when enables set
// R3 - fault enters cool-down, holds enable commands
// R4 - cool-down end restarts per enable bits
// R5 - power-off clears both enables; host re-sets
// R6 - detect, classify, 100 ms step, then power
// R7 - monitor signature, remove power on disconnect
// R8 - keep power on 6 ms per 320 ms
// R9 - powered port applies foldback and policing
// R10 - reset held until both supplies valid
// R11 - address from four strap pins, unique
// R12 - host programs memory and initial config; here no memory, only the CTRL config-loaded flag and strap
// R13 - cool-down and foldback parameterised, per port; here one COOL_CYC and FOLDBACK_LIMIT for all ports
module poe_port_restart_sequencer #(
  parameter int unsigned LONG_CLASS_CYC = `LONG_CLASS_MS * `CLK_MHZ * 1000,
  parameter int unsigned MPS_HOLD_CYC   = `MPS_HOLD_MS * `CLK_MHZ * 1000,
  parameter int unsigned MPS_WIN_CYC    = `MPS_WIN_MS * `CLK_MHZ * 1000,
  parameter int unsigned COOL_CYC       = `COOL_MS * `CLK_MHZ * 1000,
  parameter logic [7:0]  FOLDBACK_LIMIT = `FOLDBACK_DEF
) (
  input  wire logic                   CLOCK,
  input  wire logic                   NRST,
  poe_link_if.dev                     LINK,
  input  wire logic [`NPORT-1:0]      DET_VALID,
  input  wire logic [`NPORT-1:0]      CLS_DONE,
  input  wire logic [`NPORT-1:0]      START_FAULT,
  input  wire logic [`NPORT-1:0]      POLICING_FAULT,
  input  wire logic [`NPORT-1:0]      CURRENT_LIMIT_FAULT,
  input  wire logic [`NPORT-1:0]      MPS_PRESENT,
  output logic      [`NPORT-1:0]      PORT_POWER_EN,
  output logic      [`NPORT-1:0]      DETECT_ACTIVE,
  output logic      [`NPORT-1:0]      CLASS_ACTIVE,
  output logic      [`NPORT-1:0][7:0] FOLDBACK_OUT,
  output logic      [`NPORT-1:0][7:0] POLICING_OUT,
  output logic      [3:0]             I2C_ADDR
);
  import poe_seq_pkg::*;

  dev_state_t q;
  dev_state_t n;
  logic [`NPORT-1:0] fault;
  logic [`NPORT-1:0] mps_now;

  always_comb begin
    n = q;
    n.s1 = {MPS_PRESENT, CURRENT_LIMIT_FAULT, POLICING_FAULT,
            START_FAULT, CLS_DONE, DET_VALID};
    n.s2 = q.s1;
    // R11 address strap
    n.a1 = LINK.strap;
    n.a2 = q.a1;
    n.fault_ev = '0;
    n.disc_ev = '0;
    fault = '0;
    mps_now = '0;
    for (int p = 0; p < `NPORT; p++) begin
      fault[p] = q.s2[`S_STF][p] | q.s2[`S_PCF][p] | q.s2[`S_ILF][p];
      mps_now[p] = q.s2[`S_MPS][p];
      // R5 off clears enables
      if (LINK.pwr_off[p]) begin
        n.det_en[p] = 1'b0;
        n.cls_en[p] = 1'b0;
      end
      // a set in the same cycle as an off wins, so no command is lost
      if (LINK.det_set[p]) begin
        n.det_en[p] = 1'b1;
      end
      if (LINK.cls_set[p]) begin
        n.cls_en[p] = 1'b1;
      end
      case (q.st[p])
        ST_IDLE: begin
          // R12 wait for host config
          if (LINK.cfg_loaded && !LINK.pwr_off[p]) begin
            // R2 restart after disconnect
            if (q.det_en[p]) begin
              n.st[p] = ST_DETECT;
            end else if (q.cls_en[p]) begin
              n.st[p] = ST_CLASS;
            end
          end
        end
        ST_DETECT: begin
          // R6 detection first
          if (LINK.pwr_off[p]) begin
            n.st[p] = ST_IDLE;
          end else if (q.s2[`S_DET][p]) begin
            n.st[p] = q.cls_en[p] ? ST_CLASS : ST_IDLE;
          end
        end
        ST_CLASS: begin
          if (LINK.pwr_off[p]) begin
            n.st[p] = ST_IDLE;
          end else if (q.s2[`S_CLS][p]) begin
            n.st[p] = ST_LONG;
            n.tmr[p] = '0;
          end
        end
        ST_LONG: begin
          // R6 long final class step
          n.tmr[p] = q.tmr[p] + 32'h1;
          if (LINK.pwr_off[p]) begin
            n.st[p] = ST_IDLE;
          end else if (q.tmr[p] == 32'(LONG_CLASS_CYC - 1)) begin
            n.tmr[p] = '0;
            n.acc[p] = '0;
            n.st[p] = q.det_en[p] ? ST_POWER : ST_IDLE;
          end
        end
        ST_POWER: begin
          n.tmr[p] = q.tmr[p] + 32'h1;
          if (mps_now[p] && q.acc[p] < 32'(MPS_HOLD_CYC)) begin
            n.acc[p] = q.acc[p] + 32'h1;
          end
          if (LINK.pwr_off[p]) begin
            // R1 host power-off
            n.st[p] = ST_IDLE;
          end else if (fault[p]) begin
            // R3 fault starts cool-down
            n.st[p] = ST_COOL;
            n.tmr[p] = '0;
            n.fault_ev[p] = 1'b1;
          end else if (q.tmr[p] == 32'(MPS_WIN_CYC - 1)) begin
            // R8 hold within window; the last sample counts too
            n.tmr[p] = '0;
            if (n.acc[p] < 32'(MPS_HOLD_CYC)) begin
              // R7 signature lost
              n.st[p] = ST_IDLE;
              n.disc_ev[p] = 1'b1;
            end
            n.acc[p] = '0;
          end
        end
        ST_COOL: begin
          // R13 per-port cool-down
          n.tmr[p] = q.tmr[p] + 32'h1;
          if (q.tmr[p] == 32'(COOL_CYC - 1)) begin
            // R4 restart from stored enables
            n.tmr[p] = '0;
            n.st[p] = ST_IDLE;
          end
        end
        default: begin
          n.st[p] = ST_IDLE;
        end
      endcase
      n.pwr_en[p] = (n.st[p] == ST_POWER);
      n.det_act[p] = (n.st[p] == ST_DETECT);
      n.cls_act[p] = (n.st[p] == ST_CLASS) || (n.st[p] == ST_LONG);
      // R9 foldback with policing
      n.lim[p] = n.pwr_en[p] ? FOLDBACK_LIMIT : 8'h00;
      n.pcut[p] = n.pwr_en[p] ? LINK.police : 8'h00;
    end
    // R10 held while supplies low
    if (!LINK.dev_rst_n) begin
      n = '0;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign LINK.det_en   = q.det_en;
  assign LINK.cls_en   = q.cls_en;
  assign LINK.powered  = q.pwr_en;
  assign LINK.fault_ev = q.fault_ev;
  assign LINK.disc_ev  = q.disc_ev;
  assign LINK.dev_addr = q.a2;
  assign PORT_POWER_EN = q.pwr_en;
  assign DETECT_ACTIVE = q.det_act;
  assign CLASS_ACTIVE  = q.cls_act;
  assign FOLDBACK_OUT  = q.lim;
  assign POLICING_OUT  = q.pcut;
  assign I2C_ADDR      = q.a2;

endmodule

// ---- poe_host_ctrl.sv ----
// host controller end: AHB-Lite registers driving the sequencer link
// assumes one AHB-Lite master on CLOCK and supply-good inputs from pins
`timescale 1ns/1ps
`include "poe_seq_map.svh"

module poe_host_ctrl (
  input  wire logic        CLOCK,
  input  wire logic        NRST,
  poe_link_if.host         LINK,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic             IRQ,
  input  wire logic        HV_SUPPLY_OK,
  input  wire logic        LOGIC_SUPPLY_OK
);
  import poe_seq_pkg::*;

  host_state_t q;
  host_state_t n;

  always_comb begin
    n = q;
    n.sv1 = {HV_SUPPLY_OK, LOGIC_SUPPLY_OK};
    n.sv2 = q.sv1;
    // R10 release only with both supplies
    n.rst_n = &q.sv2;
    n.det_set = '0;
    n.cls_set = '0;
    n.pwr_off = '0;
    // only whole-word single transfers; size is not checked
    if (HSEL && HTRANS[1] && HREADY) begin
      n.act = 1'b1;
      n.wr = HWRITE;
      n.addr = HADDR[7:0];
      case (HADDR[7:0])
        `OFS_CTRL:   n.rdata = {24'h0, q.strap, 3'h0, q.cfg};
        `OFS_POLICE: n.rdata = {24'h0, q.police};
        `OFS_PSTAT:  n.rdata = {4'h0, LINK.dev_addr, LINK.cls_en,
                                LINK.det_en, LINK.powered};
        `OFS_ISTAT:  n.rdata = {16'h0, q.ists};
        `OFS_IMASK:  n.rdata = {16'h0, q.imask};
        default:     n.rdata = 32'h0;
      endcase
    end else begin
      n.act = 1'b0;
    end
    if (q.act && q.wr) begin
      case (q.addr)
        `OFS_CTRL: begin
          // R12 config loaded flag
          n.cfg = HWDATA[`CTRL_CFG_BIT];
          // R11 strap choice
          n.strap = HWDATA[`CTRL_STRAP_LSB +: 4];
        end
        `OFS_CMD: begin
          // R5 host re-enables
          n.det_set = HWDATA[`CMD_DET_LSB +: `NPORT];
          n.cls_set = HWDATA[`CMD_CLS_LSB +: `NPORT];
          n.pwr_off = HWDATA[`CMD_OFF_LSB +: `NPORT];
        end
        `OFS_POLICE: n.police = HWDATA[7:0];
        `OFS_ISTAT:  n.ists = q.ists & ~HWDATA[15:0];
        `OFS_IMASK:  n.imask = HWDATA[15:0];
        default: begin
        end
      endcase
    end
    // new events win over a same-cycle clear
    n.ists = n.ists | {LINK.disc_ev, LINK.fault_ev};
    n.irq = |(n.ists & n.imask);
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign LINK.dev_rst_n  = q.rst_n;
  assign LINK.cfg_loaded = q.cfg;
  assign LINK.strap      = q.strap;
  assign LINK.police     = q.police;
  assign LINK.det_set    = q.det_set;
  assign LINK.cls_set    = q.cls_set;
  assign LINK.pwr_off    = q.pwr_off;
  assign HRDATA          = q.rdata;
  assign HREADYOUT       = 1'b1;
  assign HRESP           = 1'b0;
  assign IRQ             = q.irq;

endmodule

// ---- poe_link_asserts.sv ----
// link checker: sequencer against its host controller
// assumes one clock; link signals arrive as plain inputs
`timescale 1ns/1ps
`include "poe_seq_map.svh"
module poe_link_asserts #(
  parameter int unsigned COOL_CYC = 30
) (
  input wire logic              CLOCK,
  input wire logic              NRST,
  input wire logic              dev_rst_n,
  input wire logic              cfg_loaded,
  input wire logic [3:0]        strap,
  input wire logic [`NPORT-1:0] det_set,
  input wire logic [`NPORT-1:0] cls_set,
  input wire logic [`NPORT-1:0] pwr_off,
  input wire logic [`NPORT-1:0] det_en,
  input wire logic [`NPORT-1:0] cls_en,
  input wire logic [`NPORT-1:0] powered,
  input wire logic [`NPORT-1:0] fault_ev,
  input wire logic [`NPORT-1:0] disc_ev,
  input wire logic [3:0]        dev_addr
);
  logic [`NPORT-1:0] fmask_q;
  int unsigned       fcnt_q;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // ports of the last fault and cycles since; a later fault restarts it
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      fmask_q <= '0;
      fcnt_q <= 0;
    end else if (fault_ev != '0) begin
      fmask_q <= fault_ev;
      fcnt_q <= 0;
    end else if (fcnt_q < COOL_CYC) begin
      fcnt_q <= fcnt_q + 1;
    end
  end
  a_fault_unpowers: assert property (
    fault_ev != '0 |=> (powered & $past(fault_ev)) == '0)
    else $error("fault left port powered");
  a_off_unpowers: assert property (
    pwr_off != '0 |=> ##1 (powered & $past(pwr_off, 2)) == '0)
    else $error("power-off left port powered");
  a_off_clears_en: assert property (
    pwr_off != '0 |=>
    (((det_en & ~$past(det_set)) | (cls_en & ~$past(cls_set)))
     & $past(pwr_off)) == '0)
    else $error("power-off kept enables");
  a_set_enables: assert property (
    dev_rst_n && cfg_loaded && det_set != '0 |=>
    (det_en & $past(det_set)) == $past(det_set))
    else $error("detect set not taken");
  a_cool_unpowered: assert property (
    fcnt_q < COOL_CYC |-> (powered & fmask_q) == '0)
    else $error("port powered during cool-down");
  a_disc_unpowers: assert property (
    disc_ev != '0 |=> (powered & $past(disc_ev)) == '0)
    else $error("disconnect left port powered");
  a_power_needs_en: assert property (
    (powered & ~$past(powered)) != '0 |->
    (powered & ~$past(powered) & ~(det_en & cls_en)) == '0)
    else $error("power without both enables");
  a_addr_strap: assert property (
    (dev_rst_n && $stable(strap)) [*5] |-> dev_addr == strap)
    else $error("address differs from strap");
  a_rst_clears: assert property (
    !dev_rst_n [*2] |=> powered == '0 && det_en == '0 && cls_en == '0)
    else $error("device active in reset");
  c_fault: cover property (fault_ev != '0);
  c_disc: cover property (disc_ev != '0);
  c_off: cover property (pwr_off != '0);
endmodule

// ---- test_poe_port_restart_sequencer.sv ----
// bench: host controller and sequencer joined by the link
// assumes shortened counts; port front-end levels come from the bench
`timescale 1ns/1ps
`include "poe_seq_map.svh"
module test_poe_port_restart_sequencer;
  import poe_seq_pkg::*;
  localparam int LONG = 20;
  localparam int COOL = 30;
  logic                   CLOCK, NRST, hsel, hwrite, hv_ok, lg_ok;
  logic                   hreadyout, hresp, irq;
  logic [1:0]             htrans;
  logic [2:0]             hsize, p;
  logic [31:0]            haddr, hwdata, hrdata, r;
  logic [`NPORT-1:0]      det_ok, cls_ok, mps, pwr, det_a, cls_a;
  logic [`NPORT-1:0]      flt [3];
  logic [`NPORT-1:0][7:0] fold, pol;
  logic [3:0]             addr;
  logic [15:0]            seed;
  int                     bad_count, cmp_count, n, k;
  int                     m_det, m_cls, m_ists, m_mask;
  int                     m_evq[$];
  wire  [3:0]             stv = {hreadyout, cls_a[p], det_a[p], pwr[p]};
  poe_link_if link ();
  poe_port_restart_sequencer #(.LONG_CLASS_CYC(LONG), .MPS_HOLD_CYC(3),
    .MPS_WIN_CYC(16), .COOL_CYC(COOL)) i_poe_port_restart_sequencer (
    .CLOCK(CLOCK), .NRST(NRST), .LINK(link), .DET_VALID(det_ok),
    .CLS_DONE(cls_ok), .START_FAULT(flt[0]), .POLICING_FAULT(flt[1]),
    .CURRENT_LIMIT_FAULT(flt[2]), .MPS_PRESENT(mps), .PORT_POWER_EN(pwr),
    .DETECT_ACTIVE(det_a), .CLASS_ACTIVE(cls_a), .FOLDBACK_OUT(fold),
    .POLICING_OUT(pol), .I2C_ADDR(addr));
  poe_host_ctrl i_poe_host_ctrl (.CLOCK(CLOCK), .NRST(NRST), .LINK(link),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .IRQ(irq),
    .HV_SUPPLY_OK(hv_ok), .LOGIC_SUPPLY_OK(lg_ok));
  poe_link_asserts #(.COOL_CYC(COOL)) i_poe_link_asserts (.CLOCK(CLOCK),
    .NRST(NRST), .dev_rst_n(link.dev_rst_n), .cfg_loaded(link.cfg_loaded),
    .strap(link.strap), .det_set(link.det_set), .cls_set(link.cls_set),
    .pwr_off(link.pwr_off), .det_en(link.det_en), .cls_en(link.cls_en),
    .powered(link.powered),
    .fault_ev(link.fault_ev), .disc_ev(link.disc_ev),
    .dev_addr(link.dev_addr));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait for one watched level; a hang ends the run
  task automatic wt(input int s, input logic v);
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (stv[s] !== v && n < 400);
    if (stv[s] !== v) begin
      chk("wait", 32'(v), 32'(stv[s]));
      report_and_stop();
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wt(3, 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt(3, 1'b1);
    r = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask
  // model: enables follow the command rules, a set beats a power-off
  task automatic cmd(input logic [31:0] d);
    ahb(1'b1, `OFS_CMD, d);
    m_det = (m_det & ~int'(d[23:16])) | int'(d[7:0]);
    m_cls = (m_cls & ~int'(d[23:16])) | int'(d[15:8]);
  endtask
  task automatic pstat(input logic [7:0] pw);
    ahb(1'b0, `OFS_PSTAT, 32'h0);
    chk("pstat", {4'h0, seed[7:4], 8'(m_cls), 8'(m_det), pw}, r);
  endtask
  // model: queued events become sticky status bits when read
  task automatic istat();
    while (m_evq.size() > 0) begin
      m_ists = m_ists | m_evq.pop_front();
    end
    ahb(1'b0, `OFS_ISTAT, 32'h0);
    chk("istat", 32'(m_ists), r);
    chk("irq", 32'((m_ists & m_mask) != 0), 32'(irq));
  endtask
  initial begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end
  initial begin
    {NRST, hsel, hwrite, hv_ok, lg_ok, htrans, haddr, hwdata} = '0;
    {det_ok, cls_ok, mps, flt[0], flt[1], flt[2]} = '0;
    hsize = 3'h2;
    bad_count = 0;
    cmp_count = 0;
    {m_det, m_cls, m_ists, m_mask} = '0;
    seed = lfsr(16'h2A37);
    p = seed[2:0];
    repeat (10) @(posedge CLOCK);
    NRST <= 1'b1;
    hv_ok <= 1'b1;
    repeat (6) @(posedge CLOCK);
    chk("dev reset", 32'h0, 32'(link.dev_rst_n));
    lg_ok <= 1'b1;
    ahb(1'b1, `OFS_CTRL, {24'h0, seed[7:4], 4'h1});
    ahb(1'b1, `OFS_POLICE, {24'h0, seed[15:8]});
    ahb(1'b1, `OFS_IMASK, 32'h0000FFFF);
    m_mask = 32'hFFFF;
    repeat (8) @(posedge CLOCK);
    pstat(8'h0);
    det_ok[p] <= 1'b1;
    cls_ok[p] <= 1'b1;
    mps[p] <= 1'b1;
    cmd(32'h101 << p);
    wt(2, 1'b1);
    wt(0, 1'b1);
    chk("long class", 32'h1, 32'(n >= LONG && n <= LONG + 6));
    @(posedge CLOCK);
    chk("foldback", `FOLDBACK_DEF, fold[p]);
    chk("policing", seed[15:8], pol[p]);
    repeat (4) begin
      mps[p] <= 1'b1;
      repeat (4) @(posedge CLOCK);
      mps[p] <= 1'b0;
      repeat (12) @(posedge CLOCK);
    end
    mps[p] <= 1'b1;
    pstat(8'h1 << p);
    mps[p] <= 1'b0;
    m_evq.push_back(32'h100 << p);
    wt(0, 1'b0);
    istat();
    wt(2, 1'b1);
    mps[p] <= 1'b1;
    wt(0, 1'b1);
    ahb(1'b1, `OFS_ISTAT, 32'h0000FFFF);
    m_ists = m_ists & ~32'hFFFF;
    istat();
    for (k = 0; k < 3; k++) begin
      flt[k][p] <= 1'b1;
      m_evq.push_back(32'h1 << p);
      wt(0, 1'b0);
      flt[k][p] <= 1'b0;
      cmd(32'h101 << p);
      wt(0, 1'b1);
      chk("cool", 32'h1, 32'(n > COOL + LONG - 4 && n < COOL + LONG + 12));
    end
    istat();
    ahb(1'b1, `OFS_IMASK, 32'h0);
    m_mask = 0;
    @(posedge CLOCK);
    chk("masked irq", 32'((m_ists & m_mask) != 0), 32'(irq));
    cmd(32'h10000 << p);
    wt(0, 1'b0);
    repeat (COOL) @(posedge CLOCK);
    chk("stay off", 32'h0, 32'(pwr[p] | det_a[p] | cls_a[p]));
    pstat(8'h0);
    cmd(32'h101 << p);
    wt(0, 1'b1);
    lg_ok <= 1'b0;
    wt(0, 1'b0);
    chk("supply drop", 32'h0, 32'({link.det_en, link.cls_en}));
    ahb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, r);
    report_and_stop();
  end
endmodule
